// ==== include/cfsc_pkg.sv ====
// package: constants and types for the clock fan-out serial control port
package cfsc_pkg;
	// ----------------------------------------
	// bus addressing
	// ----------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h69;
	localparam logic [7:0] ADDR_WRITE_BYTE = 8'hd2;
	localparam logic [7:0] ADDR_READ_BYTE = 8'hd3;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int NUM_REGS = 7;
	localparam logic [7:0] OFS_OUTPUT_ENABLE_CTRL = 8'h00;
	localparam logic [7:0] OFS_SPARE_CTRL_A = 8'h01;
	localparam logic [7:0] OFS_SPARE_CTRL_E = 8'h05;
	localparam logic [7:0] OFS_IDENTIFICATION = 8'h06;
	localparam int OE_OUT5_BIT = 3;
	localparam int OE_OUT8_BIT = 0;
	localparam logic [3:0] OE_RESET = 4'hf;
	localparam logic [7:0] SPARE_RESET = 8'h00;
	localparam int SILICON_REV_LSB = 4;
	localparam int MAKER_CODE_LSB = 0;
	// ----------------------------------------
	// link states and carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRX, ST_WRX_ACK, ST_RDX, ST_RDX_ACK
	} cfsc_state_t;
	typedef enum logic [1:0] {PH_OFFSET, PH_COUNT, PH_DATA} cfsc_phase_t;
	typedef struct packed {
		logic [7:0] silicon_rev_field;
		logic [7:0] maker_code_field;
	} cfsc_ident_t;
endpackage

// ==== hw/cfsc_target.sv ====
// file: two-wire target port and register file of the clock fan-out device
`timescale 1ns/1ps
// Contract
// (R01) The block only answers as a target at one 7-bit address and only does block writes and reads.
// (R02) The address byte is seven address bits and a direction bit, d2 to write and d3 to read.
// (R03) The first byte after the write address sets the 8-bit register offset pointer.
// (R04) Offset 0 bits 3..0 enable outputs five to eight, power up as 1, bits 7..4 are plain storage.
// (R05) Offsets 1 to 5 store written bytes and affect nothing.
// (R06) Offset 6 reads a fixed revision nibble above a fixed maker nibble.
// (R07) A count byte follows the offset, then consecutive registers are written or read, each acked.
// (R08) The host reads by a repeated start with the read address, acks bytes, then nacks and stops.
// (R09) A disabled clock output is left undriven instead of driven.
module cfsc_target #(
	parameter logic [3:0] SILICON_REV = 4'h0, // arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h5 // arbitrary value
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [3:0] out_clk_src,
	output logic [3:0] out_clk,
	output logic [3:0] out_clk_oe
);
	// ----------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------
	logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
	logic scl_q, sda_q, scl_d, sda_d;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	always_comb begin
		scl_sync_d = {scl_sync_q[0], scl_in};
		sda_sync_d = {sda_sync_q[0], sda_in};
		scl_d = scl_sync_q[1];
		sda_d = sda_sync_q[1];
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (clk_en) begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end
	assign scl_rise = scl_d && !scl_q;
	assign scl_fall = !scl_d && scl_q;
	// start and stop are data edges while the clock stays high
	assign start_ev = scl_d && scl_q && sda_q && !sda_d;
	assign stop_ev = scl_d && scl_q && !sda_q && sda_d;

	// ----------------------------------------
	// byte engine and register file
	// ----------------------------------------
	cfsc_pkg::cfsc_state_t st_q, st_d;
	cfsc_pkg::cfsc_phase_t ph_q, ph_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d, cnt_q, cnt_d;
	logic [2:0] bit_q, bit_d;
	logic rw_q, rw_d, sda_oe_q, sda_oe_d, nack_q, nack_d, done_q, done_d;
	logic [7:0] regs_q [cfsc_pkg::NUM_REGS];
	logic [7:0] regs_d [cfsc_pkg::NUM_REGS];
	logic [7:0] rd_byte;
	cfsc_pkg::cfsc_ident_t ident;

	// read mux: the identification byte ignores stored writes
	function automatic logic [7:0] reg_read(input logic [7:0] ofs,
		input logic [7:0] file [cfsc_pkg::NUM_REGS], input logic [7:0] idb);
		logic [7:0] r;
		r = 8'h00;
		if (ofs == cfsc_pkg::OFS_IDENTIFICATION) begin
			r = idb;
		end else if (ofs < cfsc_pkg::OFS_IDENTIFICATION) begin
			r = file[ofs[2:0]];
		end
		return r;
	endfunction

	always_comb begin
		// (R06) fixed identity nibbles
		ident.silicon_rev_field = 8'({SILICON_REV, 4'h0});
		ident.maker_code_field = 8'({4'h0, MAKER_CODE});
	end
	assign rd_byte = reg_read(ptr_q, regs_q,
		ident.silicon_rev_field | ident.maker_code_field);

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		bit_d = bit_q;
		rw_d = rw_q;
		sda_oe_d = sda_oe_q;
		nack_d = nack_q;
		done_d = done_q;
		regs_d = regs_q;
		if (stop_ev) begin
			st_d = cfsc_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_ev) begin
			// a repeated start keeps the pointer for the read that follows
			st_d = cfsc_pkg::ST_ADDR;
			bit_d = 3'h7;
			sda_oe_d = 1'b0;
			done_d = 1'b0;
		end else begin
			unique case (st_q)
			cfsc_pkg::ST_IDLE: begin
			end
			cfsc_pkg::ST_ADDR, cfsc_pkg::ST_WRX: begin
				if (scl_rise) begin
					shift_d = {shift_q[6:0], sda_d};
					bit_d = bit_q - 3'h1;
					// the first fall after a start comes before any bit, so count rises
					done_d = (bit_q == 3'h0);
				end
				if (scl_fall && done_q && st_q == cfsc_pkg::ST_ADDR) begin
					// (R01) (R02) only our seven address bits are acknowledged
					if (shift_q[7:1] == cfsc_pkg::TARGET_ADDR) begin
						rw_d = shift_q[0];
						sda_oe_d = 1'b1;
						st_d = cfsc_pkg::ST_ADDR_ACK;
						if (!shift_q[0]) begin
							ph_d = cfsc_pkg::PH_OFFSET;
						end
					end else begin
						st_d = cfsc_pkg::ST_IDLE;
					end
				end else if (scl_fall && done_q && st_q == cfsc_pkg::ST_WRX) begin
					sda_oe_d = 1'b1;
					st_d = cfsc_pkg::ST_WRX_ACK;
					unique case (ph_q)
					// (R03) offset pointer
					cfsc_pkg::PH_OFFSET: begin
						ptr_d = shift_q;
						ph_d = cfsc_pkg::PH_COUNT;
					end
					// (R07) count, then consecutive register data
					cfsc_pkg::PH_COUNT: begin
						cnt_d = shift_q;
						ph_d = cfsc_pkg::PH_DATA;
					end
					cfsc_pkg::PH_DATA: begin
						// (R04) (R05) offsets 0..5 store; offset 6 is fixed
						if (ptr_q < cfsc_pkg::OFS_IDENTIFICATION) begin
							regs_d[ptr_q[2:0]] = shift_q;
						end
						ptr_d = ptr_q + 8'h01;
						cnt_d = cnt_q - 8'h01;
					end
					default: begin
					end
					endcase
				end
			end
			cfsc_pkg::ST_ADDR_ACK, cfsc_pkg::ST_WRX_ACK: begin
				if (scl_fall) begin
					bit_d = 3'h7;
					done_d = 1'b0;
					if (rw_q) begin
						st_d = cfsc_pkg::ST_RDX;
						shift_d = rd_byte;
						sda_oe_d = !rd_byte[7];
					end else begin
						st_d = cfsc_pkg::ST_WRX;
						sda_oe_d = 1'b0;
					end
				end
			end
			cfsc_pkg::ST_RDX: begin
				if (scl_fall) begin
					if (bit_q == 3'h0) begin
						sda_oe_d = 1'b0;
						st_d = cfsc_pkg::ST_RDX_ACK;
						ptr_d = ptr_q + 8'h01;
					end else begin
						shift_d = {shift_q[6:0], 1'b0};
						sda_oe_d = !shift_q[6];
						bit_d = bit_q - 3'h1;
					end
				end
			end
			cfsc_pkg::ST_RDX_ACK: begin
				if (scl_rise) begin
					nack_d = sda_d;
				end
				if (scl_fall) begin
					// (R08) host nack ends the read; stop follows
					if (nack_q) begin
						st_d = cfsc_pkg::ST_IDLE;
					end else begin
						st_d = cfsc_pkg::ST_RDX;
						bit_d = 3'h7;
						shift_d = rd_byte;
						sda_oe_d = !rd_byte[7];
					end
				end
			end
			default: begin
				st_d = cfsc_pkg::ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= cfsc_pkg::ST_IDLE;
			ph_q <= cfsc_pkg::PH_OFFSET;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 8'h00;
			bit_q <= 3'h7;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
			for (int i = 0; i < cfsc_pkg::NUM_REGS; i++) begin
				regs_q[i] <= cfsc_pkg::SPARE_RESET;
			end
			// (R04) outputs enabled at power up
			regs_q[0] <= {4'h0, cfsc_pkg::OE_RESET};
		end else if (clk_en) begin
			st_q <= st_d;
			ph_q <= ph_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			rw_q <= rw_d;
			sda_oe_q <= sda_oe_d;
			nack_q <= nack_d;
			done_q <= done_d;
			regs_q <= regs_d;
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_q;
	// (R09) disabled outputs float; the pad adds the weak pull-down
	assign out_clk_oe = regs_q[0][cfsc_pkg::OE_OUT5_BIT:cfsc_pkg::OE_OUT8_BIT];
	assign out_clk = out_clk_src & out_clk_oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	addr_ack_drive_a: assert property (st_q == cfsc_pkg::ST_ADDR_ACK |-> sda_oe_q) // R02
		else $error("address ack not driven");
	oe_pin_map_a: assert property (out_clk_oe == regs_q[0][3:0]) // R09
		else $error("output enable does not follow control bits");
	wr_ack_drive_a: assert property (st_q == cfsc_pkg::ST_WRX_ACK |-> sda_oe_q) // R07
		else $error("write byte not acked");
	offset_load_a: assert property (clk_en && st_q == cfsc_pkg::ST_WRX_ACK
		&& $past(ph_q) == cfsc_pkg::PH_OFFSET && ph_q == cfsc_pkg::PH_COUNT
		|-> ptr_q == $past(shift_q)) // R03
		else $error("offset pointer not loaded");
	foreign_addr_a: assert property (clk_en && st_q == cfsc_pkg::ST_ADDR && scl_fall
		&& done_q && shift_q[7:1] != cfsc_pkg::TARGET_ADDR && !start_ev && !stop_ev
		|=> st_q == cfsc_pkg::ST_IDLE) // R01
		else $error("foreign address answered");
	ident_fixed_a: assert property (ptr_q == cfsc_pkg::OFS_IDENTIFICATION
		|-> rd_byte == {SILICON_REV, MAKER_CODE}) // R06
		else $error("identification byte wrong");
	spare_noeffect_a: assert property (clk_en && $changed(out_clk_oe) |-> // R05
		$past(ptr_q) == cfsc_pkg::OFS_OUTPUT_ENABLE_CTRL && st_q == cfsc_pkg::ST_WRX_ACK)
		else $error("output enable moved without a write");
	stop_idle_a: assert property (clk_en && stop_ev |=> st_q == cfsc_pkg::ST_IDLE && !sda_oe_q) // R08
		else $error("stop did not release the bus");
	ack_cov_c: cover property (st_q == cfsc_pkg::ST_ADDR_ACK);
	wr_cov_c: cover property (st_q == cfsc_pkg::ST_WRX_ACK && ph_q == cfsc_pkg::PH_DATA);
	rd_cov_c: cover property (st_q == cfsc_pkg::ST_RDX_ACK);
endmodule

// ==== dv/cfsc_host_model.sv ====
// behavioural two-wire host that drives the serial clock and pulls data low
`timescale 1ns/1ps
module cfsc_host_model (
	input wire logic core_clk,
	input wire logic sda,
	output logic scl,
	output logic pull_sda
);
	initial begin
		scl = 1'b1;
		pull_sda = 1'b0;
	end
	// ----------------------------------------
	// bit timing
	// ----------------------------------------
	// 12 core cycles per bit gives 48 ns; data moves 2 cycles after the fall to keep hold
	task automatic pulse(input logic low);
		scl <= 1'b0;
		repeat (2) @(posedge core_clk);
		pull_sda <= low;
		repeat (4) @(posedge core_clk);
		scl <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic start();
		pulse(1'b0);
		pull_sda <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic stop();
		pulse(1'b1);
		pull_sda <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	// ninth bit: 1 releases for the device ack, 0 acks a read byte
	task automatic xbyte(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
		output logic a9);
		logic [8:0] sh;
		sh = {tx, b9};
		for (int i = 8; i >= 0; i--) begin
			pulse(~sh[i]);
			sh[i] = sda;
		end
		rx = sh[8:1];
		a9 = sh[0];
	endtask
endmodule

// ==== dv/cfsc_target_tb.sv ====
// self-checking bench for the two-wire control port
`timescale 1ns/1ps
module cfsc_target_tb;
	localparam logic [3:0] REV = 4'h3; // arbitrary value
	localparam logic [3:0] MAKER = 4'ha; // arbitrary value
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic scl, pull_sda, sda_oe, sda_out, sda, a9;
	logic [3:0] out_clk_src = 4'h0;
	logic [3:0] out_clk, out_clk_oe;
	logic [7:0] exp_q [7];
	logic [7:0] rx;
	int err_count = 0;
	int num_checks = 0;
	always #2 core_clk = ~core_clk;
	// open-drain data line with pull-up
	assign sda = (pull_sda | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
	always @(posedge core_clk) out_clk_src <= 4'($urandom);
	cfsc_target #(.SILICON_REV(REV), .MAKER_CODE(MAKER)) dut (.core_clk(core_clk),
		.arst_n(arst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .out_clk_src(out_clk_src), .out_clk(out_clk), .out_clk_oe(out_clk_oe));
	cfsc_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .pull_sda(pull_sda));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value %s: expected %h, seen %h", name, want, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic pins();
		@(negedge core_clk);
		check("enable pins", {4'h0, out_clk_oe}, {4'h0, exp_q[0][3:0]});
		check("clock pins", {4'h0, out_clk}, {4'h0, out_clk_src & exp_q[0][3:0]});
	endtask
	task automatic do_reset();
		arst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		exp_q[0] = {4'h0, cfsc_pkg::OE_RESET};
		for (int i = 1; i < 6; i++)
			exp_q[i] = cfsc_pkg::SPARE_RESET;
		exp_q[6] = {REV, MAKER};
		pins();
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] ofs, input int n);
		logic [7:0] d;
		host.start();
		host.xbyte(addr, 1'b1, rx, a9);
		check("address ack", {7'h0, a9}, {7'h0, addr != cfsc_pkg::ADDR_WRITE_BYTE});
		if (a9 === 1'b0) begin
			host.xbyte(ofs, 1'b1, rx, a9);
			check("offset ack", {7'h0, a9}, 8'h00);
			host.xbyte(8'(n), 1'b1, rx, a9);
			check("count ack", {7'h0, a9}, 8'h00);
			for (int i = 0; i < n; i++) begin
				d = 8'($urandom);
				host.xbyte(d, 1'b1, rx, a9);
				check("data ack", {7'h0, a9}, 8'h00);
				if (ofs + i < 6)
					exp_q[ofs + i] = d;
			end
		end
		host.stop();
		pins();
	endtask
	task automatic rd(input logic [7:0] ofs, input int n);
		host.start();
		host.xbyte(cfsc_pkg::ADDR_WRITE_BYTE, 1'b1, rx, a9);
		host.xbyte(ofs, 1'b1, rx, a9);
		host.start();
		host.xbyte(cfsc_pkg::ADDR_READ_BYTE, 1'b1, rx, a9);
		check("read address ack", {7'h0, a9}, 8'h00);
		for (int i = 0; i < n; i++) begin
			host.xbyte(8'hff, i == n - 1, rx, a9);
			check("read data", rx, (ofs + i < 7) ? exp_q[ofs + i] : 8'h00);
		end
		host.stop();
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [7:0] o;
		void'($urandom(32'h3d8a71a7));
		do_reset();
		rd(8'h00, 7);
		$display("test power-up values done");
		// refused addresses and a write to offset 6 must leave every register alone
		wr(8'ha4, 8'h00, 1);
		wr(cfsc_pkg::ADDR_READ_BYTE & 8'hfe ^ 8'h02, 8'h00, 1);
		wr(cfsc_pkg::ADDR_WRITE_BYTE, 8'h06, 1);
		rd(8'h05, 3);
		$display("test refusals done");
		clk_en <= 1'b0;
		repeat (20) @(posedge core_clk);
		clk_en <= 1'b1;
		pins();
		rd(8'h00, 7);
		$display("test clock enable hold done");
		for (int r = 0; r < 8; r++) begin
			o = 8'($urandom_range(5, 0));
			wr(cfsc_pkg::ADDR_WRITE_BYTE, o, $urandom_range(6 - o, 1));
			rd(8'h00, 7);
		end
		$display("test random blocks done");
		do_reset();
		rd(8'h00, 7);
		$display("test second reset done");
		stop_test();
	end
	initial begin
		repeat (80000) @(posedge core_clk);
		err_count++;
		$display("watchdog expired");
		stop_test();
	end
endmodule
